//--- swap_scratch_pkg.sv
// package: offsets, field layout, reset values and carriers of the swap and scratch bank
package swap_scratch_pkg;

   // ==========================================================
   // register map (plain port, printed offsets)
   // ==========================================================
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          HALF_W          = 16;
   localparam logic [7:0]  SWAP_LO_OFFSET  = 8'h68;
   localparam logic [7:0]  SWAP_HI_OFFSET  = 8'h69;
   localparam logic [7:0]  SCR_LO_OFFSET   = 8'h6C;
   localparam logic [7:0]  SCR_HI_OFFSET   = 8'h6D;

   // ==========================================================
   // field positions and reset values
   // ==========================================================
   localparam int          HALF_LSB        = 0;
   localparam int          HALF_MSB        = 15;
   localparam int          UPPER_LSB       = 16;
   localparam int          UPPER_MSB       = 31;
   localparam int          BYTE_W          = 8;
   localparam logic [15:0] RESERVED_READ   = 16'h0000;
   localparam logic [15:0] IDLE_READ       = 16'h0000;
   localparam logic [31:0] SWAP_RESET      = 32'h00000000;
   localparam logic [31:0] RDATA_RESET     = 32'h00000000;

   // ==========================================================
   // internal carriers
   // ==========================================================
   // internal write into the swapper from the bus or buffer side
   typedef struct packed {
      logic        valid;
      logic        wide;     // 1: 32-bit write, 0: 16-bit write
      logic [31:0] data;
   } swap_req_s;

   // status assembly request from the buffer management side
   typedef struct packed {
      logic        start;    // load bits as a fresh status word
      logic        merge;    // or bits into the word being built
      logic [31:0] bits;
   } status_req_s;

   // scan access while a buffer test mode is active
   typedef struct packed {
      logic        enable;
      logic        shift;
      logic        din;
   } scan_req_s;

endpackage

//--- word_byte_swapper.sv
// word and byte reordering for the swapper register
`timescale 1ns/1ns

module word_byte_swapper
   import swap_scratch_pkg::*;
(
   input  wire logic [31:0] data_in,
   input  wire logic        wide,
   output logic      [31:0] data_out
);

   // 32-bit write swaps words, 16-bit write swaps the bytes of the low half
   always_comb
   begin
      if (wide)
      begin
         data_out = {data_in[HALF_MSB:HALF_LSB], data_in[UPPER_MSB:UPPER_LSB]};
      end
      else
      begin
         data_out = {data_in[UPPER_MSB:UPPER_LSB],
                     data_in[BYTE_W-1:0],
                     data_in[HALF_MSB:BYTE_W]};
      end
   end

endmodule

//--- swap_scratch_regs.sv
// swapper and buffer management scratch registers with their software port
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns

module swap_scratch_regs
   import swap_scratch_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              stop,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,
   input  wire swap_req_s         swap_req,
   output logic      [DATA_W-1:0] swap_value,
   input  wire status_req_s       status_req,
   input  wire scan_req_s         scan_req,
   output logic      [DATA_W-1:0] buffer_mgmt_scratch,
   output logic                   scan_out,
   output logic                   scratch_written
);

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      logic [31:0] swap;
      logic [31:0] scratch;
      logic        written;
      logic [31:0] rdata;
   } state_s;

   state_s      state_ff;
   state_s      nxt_state;
   logic [31:0] swapped;

   // software strobes qualified by the stop bit
   logic        sw_wr;
   logic        sw_rd;
   logic        wr_swap_lo;
   logic        wr_swap_hi;
   logic        wr_scr_lo;
   logic        wr_scr_hi;
   logic        sw_scr_wr;
   logic        scan_step;
   logic        status_step;

   // ==========================================================
   // swapper datapath
   // ==========================================================
   word_byte_swapper u_swapper
   (
      .data_in  (swap_req.data),
      .wide     (swap_req.wide),
      .data_out (swapped)
   );

   // ==========================================================
   // decode
   // ==========================================================
   // software owns the bank only while the controller is stopped
   assign sw_wr       = wr && stop;
   assign sw_rd       = rd && stop;
   assign wr_swap_lo  = sw_wr && (addr == SWAP_LO_OFFSET);
   assign wr_swap_hi  = sw_wr && (addr == SWAP_HI_OFFSET);
   assign wr_scr_lo   = sw_wr && (addr == SCR_LO_OFFSET);
   assign wr_scr_hi   = sw_wr && (addr == SCR_HI_OFFSET);
   assign sw_scr_wr   = wr_scr_lo || wr_scr_hi;
   // scan outranks status assembly; software outranks both
   assign scan_step   = scan_req.enable && scan_req.shift && !sw_scr_wr;
   assign status_step = (status_req.start || status_req.merge) && !sw_scr_wr
                        && !scan_req.enable;

   // ==========================================================
   // next state
   // ==========================================================
   always_comb
   begin
      nxt_state = state_ff;

      // internal swapper writes from the bus interface or buffer unit
      if (swap_req.valid)
      begin
         if (swap_req.wide)
         begin
            nxt_state.swap = swapped;
         end
         else
         begin
            nxt_state.swap[HALF_MSB:HALF_LSB] = swapped[HALF_MSB:HALF_LSB];
         end
      end
      // test access by software lands last so it wins a collision
      if (wr_swap_lo)
      begin
         nxt_state.swap[HALF_MSB:HALF_LSB] = wdata[HALF_MSB:HALF_LSB];
      end
      if (wr_swap_hi)
      begin
         nxt_state.swap[UPPER_MSB:UPPER_LSB] = wdata[HALF_MSB:HALF_LSB];
      end

      // scan chain: shift towards the top bit
      if (scan_step)
      begin
         nxt_state.scratch = {state_ff.scratch[UPPER_MSB-1:0], scan_req.din};
         nxt_state.written = 1'b1;
      end
      // status assembly: start loads, merge accumulates flags
      else if (status_step)
      begin
         if (status_req.start)
         begin
            nxt_state.scratch = status_req.bits;
         end
         else
         begin
            nxt_state.scratch = state_ff.scratch | status_req.bits;
         end
         nxt_state.written = 1'b1;
      end
      if (wr_scr_lo)
      begin
         nxt_state.scratch[HALF_MSB:HALF_LSB] = wdata[HALF_MSB:HALF_LSB];
         nxt_state.written = 1'b1;
      end
      if (wr_scr_hi)
      begin
         nxt_state.scratch[UPPER_MSB:UPPER_LSB] = wdata[HALF_MSB:HALF_LSB];
         nxt_state.written = 1'b1;
      end

      // read data stand for exactly the cycle after the strobe
      nxt_state.rdata = {RESERVED_READ, IDLE_READ};
      if (sw_rd)
      begin
         case (addr)
            SWAP_LO_OFFSET : nxt_state.rdata[HALF_MSB:HALF_LSB] =
                                state_ff.swap[HALF_MSB:HALF_LSB];
            SWAP_HI_OFFSET : nxt_state.rdata[HALF_MSB:HALF_LSB] =
                                state_ff.swap[UPPER_MSB:UPPER_LSB];
            SCR_LO_OFFSET  : nxt_state.rdata[HALF_MSB:HALF_LSB] =
                                state_ff.scratch[HALF_MSB:HALF_LSB];
            SCR_HI_OFFSET  : nxt_state.rdata[HALF_MSB:HALF_LSB] =
                                state_ff.scratch[UPPER_MSB:UPPER_LSB];
            default        : nxt_state.rdata = {RESERVED_READ, IDLE_READ};
         endcase
      end
   end

   // ==========================================================
   // registers
   // ==========================================================
   // scratch is left out of reset on purpose: it is undefined until written
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_ff.swap    <= SWAP_RESET;
         state_ff.scratch <= nxt_state.scratch;
         state_ff.written <= 1'b0;
         state_ff.rdata   <= RDATA_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign rdata               = state_ff.rdata;
   assign swap_value          = state_ff.swap;
   assign buffer_mgmt_scratch = state_ff.scratch;
   assign scan_out            = state_ff.scratch[UPPER_MSB];
   assign scratch_written     = state_ff.written;

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   // reserved upper half never carries data back
   property p_reserved_zero;
      rdata[UPPER_MSB:UPPER_LSB] == RESERVED_READ;
   endproperty
   a_reserved_zero : assert property (p_reserved_zero)
      else $error("reserved read bits not zero");

   // 32-bit internal write swaps the two words
   property p_word_swap;
      swap_req.valid && swap_req.wide && !wr_swap_lo && !wr_swap_hi
      |=> swap_value == {$past(swap_req.data[HALF_MSB:HALF_LSB]),
                         $past(swap_req.data[UPPER_MSB:UPPER_LSB])};
   endproperty
   a_word_swap : assert property (p_word_swap)
      else $error("word swap wrong");

   // high-half view returns the top word of the swapper as it stood
   property p_high_view;
      sw_rd && (addr == SWAP_HI_OFFSET)
      |=> rdata[HALF_MSB:HALF_LSB] == $past(swap_value[UPPER_MSB:UPPER_LSB]);
   endproperty
   a_high_view : assert property (p_high_view)
      else $error("swapper high view wrong");

   // 16-bit internal write swaps bytes and keeps the top word
   property p_byte_swap;
      swap_req.valid && !swap_req.wide && !wr_swap_lo && !wr_swap_hi
      |=> swap_value == {$past(swap_value[UPPER_MSB:UPPER_LSB]),
                         $past(swap_req.data[BYTE_W-1:0]),
                         $past(swap_req.data[HALF_MSB:BYTE_W])};
   endproperty
   a_byte_swap : assert property (p_byte_swap)
      else $error("byte swap wrong");

   // stopped write then read of the scratch low half returns the written value
   sequence s_scr_write;
      sw_wr && (addr == SCR_LO_OFFSET);
   endsequence
   sequence s_quiet_read;
      sw_rd && (addr == SCR_LO_OFFSET) && !scan_req.enable
      && !status_req.start && !status_req.merge && !wr;
   endsequence
   property p_write_read;
      logic [15:0] v;
      (s_scr_write, v = wdata[HALF_MSB:HALF_LSB]) ##1 s_quiet_read
      |=> rdata[HALF_MSB:HALF_LSB] == v;
   endproperty
   a_write_read : assert property (p_write_read)
      else $error("scratch write then read mismatch");

   // merge accumulates status flags into the word being built
   property p_status_merge;
      status_step && !status_req.start
      |=> buffer_mgmt_scratch == ($past(buffer_mgmt_scratch) | $past(status_req.bits));
   endproperty
   a_status_merge : assert property (p_status_merge)
      else $error("status merge wrong");

   // scan shift moves the chain one place and shows the top bit
   property p_scan_shift;
      scan_step
      |=> buffer_mgmt_scratch == {$past(buffer_mgmt_scratch[UPPER_MSB-1:0]),
                                  $past(scan_req.din)}
          ##0 scan_out == $past(buffer_mgmt_scratch[UPPER_MSB-1]);
   endproperty
   a_scan_shift : assert property (p_scan_shift)
      else $error("scan shift wrong");

   // written flag only rises through a real scratch update
   property p_written_cause;
      $rose(scratch_written) |-> $past(sw_scr_wr || scan_step || status_step);
   endproperty
   a_written_cause : assert property (p_written_cause)
      else $error("scratch marked written without a write");

   // running controller: software write leaves swapper alone, read gives zero
   property p_ignored_access;
      wr && !stop && !swap_req.valid ##0 rd == 1'b0 |=> $stable(swap_value) ##1 1'b1;
   endproperty
   a_ignored_access : assert property (p_ignored_access)
      else $error("write honoured while running");

   property p_ignored_read;
      rd && !stop |=> rdata == {RESERVED_READ, IDLE_READ};
   endproperty
   a_ignored_read : assert property (p_ignored_read)
      else $error("read honoured while running");

   // low-half view returns the bottom word of the swapper as it stood
   property p_low_view;
      sw_rd && (addr == SWAP_LO_OFFSET)
      |=> rdata[HALF_MSB:HALF_LSB] == $past(swap_value[HALF_MSB:HALF_LSB]);
   endproperty
   a_low_view : assert property (p_low_view)
      else $error("swapper low view wrong");

   // software half write wins over an internal swap in the same cycle
   property p_sw_wins;
      swap_req.valid && wr_swap_lo
      |=> swap_value[HALF_MSB:HALF_LSB] == $past(wdata[HALF_MSB:HALF_LSB]);
   endproperty
   a_sw_wins : assert property (p_sw_wins)
      else $error("internal swap beat a software write");

   // a fresh status word replaces whatever the scratch held
   property p_status_load;
      status_step && status_req.start
      |=> buffer_mgmt_scratch == $past(status_req.bits);
   endproperty
   a_status_load : assert property (p_status_load)
      else $error("status load wrong");

   // reading the scratch upper half returns its top word
   property p_scr_high_view;
      sw_rd && (addr == SCR_HI_OFFSET)
      |=> rdata[HALF_MSB:HALF_LSB] == $past(buffer_mgmt_scratch[UPPER_MSB:UPPER_LSB]);
   endproperty
   a_scr_high_view : assert property (p_scr_high_view)
      else $error("scratch high view wrong");

endmodule

//--- host_port_model.sv
// host-side model that drives the software register port and the stop bit
`timescale 1ns/1ns

module host_port_model
   import swap_scratch_pkg::*;
(
   input  wire logic              clock,
   output logic                   stop,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] wdata,
   output logic                   wr,
   output logic                   rd,
   input  wire logic [DATA_W-1:0] rdata
);
   // ==========================================================
   // idle values at time zero
   // ==========================================================
   initial
   begin
      stop  = 1'b0;
      addr  = 8'h00;
      wdata = 32'h00000000;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   // stop takes the given level at the next clock edge, raised or lowered
   task automatic set_stop(input logic s);
      @(posedge clock);
      stop <= s;
   endtask

   // one-cycle write; released lines show the inverse so stale values never match
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= {16'h0000, d};
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~{16'h0000, d};
      #1;
   endtask

   // one-cycle read; data stand only in the following cycle
   task automatic get(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      addr <= ~a;
      #1 d = rdata;
   endtask

   // write then read of the same offset with no gap between the strobes
   task automatic put_get(input logic [7:0] a, input logic [15:0] dw,
                          output logic [31:0] dr);
      @(posedge clock);
      addr  <= a;
      wdata <= {16'h0000, dw};
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge clock);
      rd    <= 1'b0;
      addr  <= ~a;
      wdata <= ~{16'h0000, dw};
      #1 dr = rdata;
   endtask
endmodule

//--- tb_top.sv
// self-checking testbench of the swap and scratch register bank
`timescale 1ns/1ns

module tb_top;
   import swap_scratch_pkg::*;

   logic              clock = 1'b0;
   logic              srst  = 1'b1;
   logic              stop;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   swap_req_s         swap_req   = '0;
   logic [DATA_W-1:0] swap_value;
   status_req_s       status_req = '0;
   scan_req_s         scan_req   = '0;
   logic [DATA_W-1:0] scratch;
   logic              scan_out;
   logic              scratch_written;
   int                errors    = 0;
   int                cmp_count = 0;
   logic [31:0]       rv;
   logic [31:0]       sw_exp;
   logic [31:0]       sc_exp;
   logic [31:0]       d;
   logic [31:0]       e;
   logic              w;
   int unsigned       seed_init;

   // ==========================================================
   // clock, design and host model
   // ==========================================================
   always #5 clock = ~clock;

   swap_scratch_regs dut_u (.clock(clock), .srst(srst), .stop(stop), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .swap_req(swap_req),
      .swap_value(swap_value), .status_req(status_req), .scan_req(scan_req),
      .buffer_mgmt_scratch(scratch), .scan_out(scan_out),
      .scratch_written(scratch_written));

   host_port_model host_u (.clock(clock), .stop(stop), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata));

   // ==========================================================
   // helpers
   // ==========================================================
   // expected swapper contents after one internal write
   function automatic logic [31:0] swap_fn(logic [31:0] cur, logic [31:0] x, logic wide);
      return wide ? {x[15:0], x[31:16]} : {cur[31:16], x[7:0], x[15:8]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic swap_in(input logic [31:0] x, input logic wide);
      @(posedge clock);
      swap_req <= '{valid: 1'b1, wide: wide, data: x};
      @(posedge clock);
      swap_req <= '0;
      #1;
   endtask

   task automatic stat(input logic s, input logic m, input logic [31:0] b);
      @(posedge clock);
      status_req <= '{start: s, merge: m, bits: b};
      @(posedge clock);
      status_req <= '0;
      #1;
   endtask

   // scan enable stays up between shifts so status requests stay locked out
   task automatic scan_bit(input logic din);
      @(posedge clock);
      scan_req <= '{enable: 1'b1, shift: 1'b1, din: din};
      @(posedge clock);
      scan_req <= '{enable: 1'b1, shift: 1'b0, din: 1'b0};
      #1;
   endtask

   task automatic wrap_up;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog: the whole sequence needs well under 1000 cycles
   initial
   begin
      #100000;
      errors++;
      wrap_up();
   end

   // ==========================================================
   // main sequence
   // ==========================================================
   initial
   begin
      seed_init = $urandom(95671);
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      #1;
      check(rdata, 32'h00000000);
      check(swap_value, SWAP_RESET);
      check(32'(scratch_written), 32'h00000000);
      // stop low: write dropped, read gives nothing
      host_u.put(SWAP_LO_OFFSET, 16'hA5A5);
      host_u.get(SWAP_LO_OFFSET, rv);
      check(rv, 32'h00000000);
      check(swap_value, SWAP_RESET);
      host_u.set_stop(1'b1);
      // software halves of the swapper
      host_u.put(SWAP_LO_OFFSET, 16'h1234);
      host_u.put(SWAP_HI_OFFSET, 16'hABCD);
      check(swap_value, 32'hABCD1234);
      host_u.get(SWAP_LO_OFFSET, rv);
      check(rv, 32'h00001234);
      host_u.get(SWAP_HI_OFFSET, rv);
      check(rv, 32'h0000ABCD);
      host_u.put(8'h6A, 16'hFFFF);
      host_u.get(8'h6A, rv);
      check(rv, 32'h00000000);
      // internal writes: corner cases first, then random widths and data
      sw_exp = 32'hABCD1234;
      for (int i = 0; i < 22; i++)
      begin
         d = (i == 0) ? 32'h11223344 : (i == 1) ? 32'h0000AABB : $urandom;
         w = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom % 2);
         swap_in(d, w);
         sw_exp = swap_fn(sw_exp, d, w);
         check(swap_value, sw_exp);
      end
      host_u.get(SWAP_HI_OFFSET, rv);
      check(rv, {16'h0000, sw_exp[31:16]});
      // software half write against an internal swap in the same cycle
      fork
         swap_in(32'h0F1E2D3C, 1'b1);
         host_u.put(SWAP_LO_OFFSET, 16'h5A5A);
      join
      check(swap_value, 32'h2D3C5A5A);
      // status assembly: fresh load then merge
      for (int i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 32'h00000001 : $urandom;
         e = (i == 0) ? 32'h00000004 : $urandom;
         stat(1'b1, 1'b0, d);
         stat(1'b0, 1'b1, e);
         check(scratch, d | e);
      end
      check(32'(scratch_written), 32'h00000001);
      // software load of both scratch halves
      host_u.put(SCR_LO_OFFSET, 16'h8001);
      host_u.put(SCR_HI_OFFSET, 16'h8000);
      check(scratch, 32'h80008001);
      host_u.get(SCR_HI_OFFSET, rv);
      check(rv, 32'h00008000);
      // scan mode: shift left, status requests ignored meanwhile
      sc_exp = 32'h80008001;
      for (int i = 0; i < 5; i++)
      begin
         w = (i == 0) ? 1'b1 : 1'($urandom % 2);
         check(scan_out, sc_exp[31]);
         scan_bit(w);
         sc_exp = {sc_exp[30:0], w};
         check(scratch, sc_exp);
      end
      stat(1'b1, 1'b0, 32'hFFFFFFFF);
      check(scratch, sc_exp);
      @(posedge clock);
      scan_req <= '0;
      // stop low again: scratch write dropped
      host_u.set_stop(1'b0);
      host_u.put(SCR_LO_OFFSET, 16'h0000);
      host_u.get(SCR_LO_OFFSET, rv);
      check(rv, 32'h00000000);
      host_u.set_stop(1'b1);
      host_u.get(SCR_LO_OFFSET, rv);
      check(rv, {16'h0000, sc_exp[15:0]});
      // write then read back to back on the low scratch half
      host_u.put_get(SCR_LO_OFFSET, 16'h3C3C, rv);
      check(rv, 32'h00003C3C);
      wrap_up();
   end
endmodule
